/* File: inc/eqbt_map.svh */
// register offsets, reset values and field constants of the boost table tail
`ifndef EQBT_MAP_SVH
`define EQBT_MAP_SVH

`define EQBT_OFS_ENTRY13 8'h4D
`define EQBT_OFS_ENTRY14 8'h4E
`define EQBT_OFS_ENTRY15 8'h4F
`define EQBT_OFS_READBACK 8'h52
`define EQBT_OFS_CONTROL 8'h55

`define EQBT_RST_ENTRY13 8'hA5
`define EQBT_RST_ENTRY14 8'hE6
`define EQBT_RST_ENTRY15 8'hF9
`define EQBT_RST_READBACK 8'h00
`define EQBT_RST_CONTROL 8'h00

// bit 7 of the control byte is read-only and reads zero
`define EQBT_CTRL_WR_MASK 8'h7F
`define EQBT_CTRL_INIT_BIT 1

// table indices held in this bank
`define EQBT_FIRST_IDX 4'hD
`define EQBT_LAST_IDX 4'hF

// value returned for an unmapped offset
`define EQBT_RD_UNMAPPED 8'h00

`endif

/* File: inc/eqbt_pkg.sv */
// types shared by the boost table register bank
package eqbt_pkg;

   // four 2-bit stage codes, stage 0 in the top bits
   typedef struct packed {
      logic [1:0] stage0;
      logic [1:0] stage1;
      logic [1:0] stage2;
      logic [1:0] stage3;
   } eqbt_stages_type;

   // one register access from the serial management port
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } eqbt_regreq_type;

endpackage

/* File: design/eqbt_entry.sv */
// one read-write boost table entry byte
`timescale 1ns/1ps
`include "eqbt_map.svh"

module eqbt_entry #(
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic wrEn,
   input wire logic [7:0] wrData,
   output eqbt_pkg::eqbt_stages_type entryValue
);

   eqbt_pkg::eqbt_stages_type entry_r;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         entry_r <= RESET_VAL;
      end else if (wrEn) begin
         entry_r <= wrData;
      end
   end

   assign entryValue = entry_r;

endmodule

/* File: design/eqbt_regs.sv */
// boost table entries 13 to 15, applied boost readback and adaptation control
//
// Operation
// - entry 13 at 0x4D, resets 0xA5
// - entry 14 at 0x4E, resets 0xE6
// - entry 15 at 0x4F, resets 0xF9
// - four stage codes, stage 0 highest
// - read-only applied boost at 0x52, resets 0x00
`timescale 1ns/1ps
`include "eqbt_map.svh"

module eqbt_regs #(
   parameter int IDX_W = 4
) (
   input wire logic core_clk,
   input wire logic rst,
   input eqbt_pkg::eqbt_regreq_type regReq,
   output logic [7:0] regRdData,
   output logic regRdValid,
   input wire logic [IDX_W-1:0] adaptSelIndex,
   input wire logic [7:0] lowTableBoost,
   output eqbt_pkg::eqbt_stages_type appliedBoostValue,
   output logic initRecoverySequencerBit
);

   localparam int NUM_ENTRIES = 3;
   localparam logic [NUM_ENTRIES-1:0][7:0] ENTRY_OFS = {
      `EQBT_OFS_ENTRY15, `EQBT_OFS_ENTRY14, `EQBT_OFS_ENTRY13};
   localparam logic [NUM_ENTRIES-1:0][7:0] ENTRY_RST = {
      `EQBT_RST_ENTRY15, `EQBT_RST_ENTRY14, `EQBT_RST_ENTRY13};

   logic [NUM_ENTRIES-1:0][7:0] entryVal;
   logic [NUM_ENTRIES-1:0] entryHit;
   logic [NUM_ENTRIES:0][7:0] entryRdChain;

   logic [7:0] control_r;
   logic [7:0] control_nxt;
   logic [7:0] readback_r;
   logic [7:0] readback_nxt;
   logic [7:0] rdData_r;
   logic [7:0] rdData_nxt;
   logic rdValid_r;

   // boost table entries
   assign entryRdChain[0] = `EQBT_RD_UNMAPPED;

   genvar g;
   generate
      for (g = 0; g < NUM_ENTRIES; g++) begin : gen_entry
         assign entryHit[g] = (regReq.addr == ENTRY_OFS[g]);
         eqbt_entry #(
            .RESET_VAL(ENTRY_RST[g])
         ) u_entry (
            .core_clk(core_clk),
            .rst(rst),
            .wrEn(regReq.wr && entryHit[g]),
            .wrData(regReq.wdata),
            .entryValue(entryVal[g])
         );
         assign entryRdChain[g+1] = entryRdChain[g] | (entryHit[g] ? entryVal[g] : 8'h00);
      end
   endgenerate

   // adaptation control
   wire ctrlHit = (regReq.addr == `EQBT_OFS_CONTROL);
   wire ctrlWr = regReq.wr && ctrlHit;
   wire rbHit = (regReq.addr == `EQBT_OFS_READBACK);

   // bit 7 never stores, so it always reads zero
   assign control_nxt = ctrlWr ? (regReq.wdata & `EQBT_CTRL_WR_MASK) : control_r;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         control_r <= `EQBT_RST_CONTROL;
      end else begin
         control_r <= control_nxt;
      end
   end

   // the recovery sequencer acts only once the host sets this bit
   assign initRecoverySequencerBit = control_r[`EQBT_CTRL_INIT_BIT];

   // applied boost selection
   // entries below 13 live elsewhere; their value arrives on lowTableBoost
   wire selInTable = (adaptSelIndex >= IDX_W'(`EQBT_FIRST_IDX))
      && (adaptSelIndex <= IDX_W'(`EQBT_LAST_IDX));
   wire [IDX_W-1:0] selDiff = adaptSelIndex - IDX_W'(`EQBT_FIRST_IDX);
   wire [1:0] selOff = selDiff[1:0];

   assign readback_nxt = selInTable ? entryVal[selOff] : lowTableBoost;

   // one cycle of lag keeps the analog drive glitch-free on index changes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         readback_r <= `EQBT_RST_READBACK;
      end else begin
         readback_r <= readback_nxt;
      end
   end

   assign appliedBoostValue = readback_r;

   // read path; writes to the readback offset are dropped
   assign rdData_nxt = ctrlHit ? control_r
      : rbHit ? readback_r
      : entryRdChain[NUM_ENTRIES];

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdData_r <= `EQBT_RD_UNMAPPED;
         rdValid_r <= 1'b0;
      end else begin
         rdData_r <= regReq.rd ? rdData_nxt : rdData_r;
         rdValid_r <= regReq.rd;
      end
   end

   assign regRdData = rdData_r;
   assign regRdValid = rdValid_r;

   // assertions
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   wire unmappedHit = !(|entryHit) && !ctrlHit && !rbHit;

   a_entry13_write: assert property (
      regReq.wr && regReq.addr == `EQBT_OFS_ENTRY13
      |=> entryVal[0] == $past(regReq.wdata))
      else $error("entry 13 did not store written byte");

   a_entry14_write: assert property (
      regReq.wr && regReq.addr == `EQBT_OFS_ENTRY14
      |=> entryVal[1] == $past(regReq.wdata))
      else $error("entry 14 did not store written byte");

   a_entry15_write: assert property (
      regReq.wr && regReq.addr == `EQBT_OFS_ENTRY15
      |=> entryVal[2] == $past(regReq.wdata))
      else $error("entry 15 did not store written byte");

   a_entry_reset_vals: assert property (
      $past(rst) |-> entryVal[0] == `EQBT_RST_ENTRY13
      && entryVal[1] == `EQBT_RST_ENTRY14 && entryVal[2] == `EQBT_RST_ENTRY15)
      else $error("boost entries wrong after reset");

   a_stage_bit_order: assert property (
      selInTable && selOff == 2'b00
      |=> appliedBoostValue.stage0 == $past(entryVal[0][7:6])
      && appliedBoostValue.stage3 == $past(entryVal[0][1:0]))
      else $error("stage codes out of place");

   a_readback_read: assert property (
      regReq.rd && rbHit |=> regRdValid && regRdData == $past(readback_r))
      else $error("readback read returned wrong value");

   a_readback_reset: assert property (
      $past(rst) |-> readback_r == `EQBT_RST_READBACK)
      else $error("readback not zero after reset");

   a_control_write: assert property (
      ctrlWr |=> control_r == ($past(regReq.wdata) & `EQBT_CTRL_WR_MASK)
      && control_r[7] == 1'b0)
      else $error("control write mis-stored");

   a_init_bit_out: assert property (
      ctrlWr ##1 !ctrlWr
      |-> initRecoverySequencerBit == $past(regReq.wdata[`EQBT_CTRL_INIT_BIT]))
      else $error("init bit output not following control");

   a_readback_follow: assert property (
      !selInTable |=> readback_r == $past(lowTableBoost))
      else $error("readback not following low table");

   a_readback_table: assert property (
      selInTable ##1 selInTable && $stable(adaptSelIndex)
      && $stable(entryVal)
      |=> readback_r == $past(entryVal[selOff], 2))
      else $error("readback not mirroring selected entry");

   a_unmapped_zero: assert property (
      regReq.rd && unmappedHit
      |=> regRdData == `EQBT_RD_UNMAPPED)
      else $error("unmapped read not zero");

   a_rdvalid_pulse: assert property (
      regReq.rd |=> regRdValid)
      else $error("read valid missing after read");

   a_rdvalid_idle: assert property (
      !regReq.rd |=> !regRdValid)
      else $error("read valid without read");

   a_rddata_hold: assert property (
      !regReq.rd |=> $stable(regRdData))
      else $error("read data changed without read");

   a_entry_hold: assert property (
      !(regReq.wr && |entryHit) |=> $stable(entryVal))
      else $error("boost entry changed without write");

   a_control_hold: assert property (
      !ctrlWr |=> $stable(control_r))
      else $error("control changed without write");

   a_readonly_ignore: assert property (
      regReq.wr && rbHit |=> readback_r == $past(readback_nxt))
      else $error("write disturbed applied boost");

   c_write_entry13: cover property (
      regReq.wr && regReq.addr == `EQBT_OFS_ENTRY13);
   c_select_then_read: cover property (
      selInTable ##2 regReq.rd && rbHit);
   c_init_set: cover property (
      ctrlWr && regReq.wdata[`EQBT_CTRL_INIT_BIT]);
   c_leave_table: cover property (
      selInTable ##1 !selInTable);
   c_unmapped_read: cover property (
      regReq.rd && unmappedHit);

endmodule

/* File: test/test_eqbt_regs.sv */
// self-checking bench for the boost table register bank
`timescale 1ns/1ps
`include "eqbt_map.svh"

module test_eqbt_regs;
   logic core_clk;
   logic rst;
   eqbt_pkg::eqbt_regreq_type regReq;
   logic [7:0] regRdData;
   logic regRdValid;
   logic [3:0] adaptSelIndex;
   logic [7:0] lowTableBoost;
   eqbt_pkg::eqbt_stages_type appliedBoostValue;
   logic initRecoverySequencerBit;
   int err_total;
   int checks;
   logic [31:0] seed;
   logic [7:0] shadow [13:15];
   logic [7:0] val;
   logic [7:0] a;
   logic [7:0] e;

   eqbt_regs u_dut (.core_clk(core_clk), .rst(rst), .regReq(regReq), .regRdData(regRdData),
      .regRdValid(regRdValid), .adaptSelIndex(adaptSelIndex), .lowTableBoost(lowTableBoost),
      .appliedBoostValue(appliedBoostValue), .initRecoverySequencerBit(initRecoverySequencerBit));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // indices below 13 come from outside this bank
   function automatic logic [7:0] exp_boost(input logic [3:0] idx, input logic [7:0] low);
      if (idx >= 4'hD) begin
         return shadow[idx];
      end
      return low;
   endfunction

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      if (err_total == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic step();
      @(posedge core_clk);
      #1;
   endtask

   // each access ends with an idle cycle so the next task never retouches regReq at once
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      regReq = '{addr: ad, wr: 1'b1, rd: 1'b0, wdata: d};
      step();
      regReq = '0;
      step();
   endtask

   task automatic rd(input logic [7:0] ad, output logic [7:0] d);
      int n;
      regReq = '{addr: ad, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      step();
      regReq = '0;
      n = 0;
      while (regRdValid !== 1'b1 && n < 4) begin
         step();
         n++;
      end
      if (n == 4) begin
         chk("read valid", 8'h00, 8'h01);
         end_of_test();
      end else begin
         chk("read latency", 8'(n), 8'h00);
         d = regRdData;
         step();
         chk("read valid pulse", {7'h00, regRdValid}, 8'h00);
         chk("read data hold", regRdData, d);
      end
   endtask

   initial begin
      err_total = 0;
      checks = 0;
      seed = 32'd38;
      rst = 1'b1;
      regReq = '0;
      adaptSelIndex = 4'h0;
      lowTableBoost = 8'h00;
      shadow[13] = 8'hA5;
      shadow[14] = 8'hE6;
      shadow[15] = 8'hF9;
      repeat (20) step();
      rst = 1'b0;
      rd(8'h4D, val); chk("entry13 reset", val, 8'hA5);
      rd(8'h4E, val); chk("entry14 reset", val, 8'hE6);
      rd(8'h4F, val); chk("entry15 reset", val, 8'hF9);
      rd(8'h52, val); chk("readback reset", val, 8'h00);
      rd(8'h55, val); chk("control reset", val, 8'h00);
      chk("init bit reset", {7'h00, initRecoverySequencerBit}, 8'h00);
      wr(8'h55, 8'hFF);
      rd(8'h55, val); chk("control bit7", val, 8'h7F);
      wr(8'h55, 8'h02);
      rd(8'h55, val); chk("control init", val, 8'h02);
      chk("init bit", {7'h00, initRecoverySequencerBit}, 8'h01);
      rd(8'h4C, val); chk("unmapped 4C", val, 8'h00);
      rd(8'h56, val); chk("unmapped 56", val, 8'h00);
      for (int i = 0; i < 40; i++) begin
         seed = xorshift(seed);
         val = seed[7:0];
         a = 8'h4D + 8'(seed[9:8] % 2'd3);
         wr(a, val);
         shadow[a[3:0]] = val;
         wr(8'h52, ~val);
         adaptSelIndex = (i < 3) ? 4'(4'hD + i) : seed[13:10];
         lowTableBoost = seed[31:24];
         step();
         e = exp_boost(adaptSelIndex, lowTableBoost);
         chk("applied boost", appliedBoostValue, e);
         chk("stage0", {6'h00, appliedBoostValue.stage0}, {6'h00, e[7:6]});
         chk("stage3", {6'h00, appliedBoostValue.stage3}, {6'h00, e[1:0]});
         rd(8'h52, val); chk("readback", val, e);
         rd(a, val); chk("entry readback", val, shadow[a[3:0]]);
      end
      // second reset after traffic: every stored byte must return to its reset value
      rst = 1'b1;
      repeat (2) step();
      chk("readback in reset", appliedBoostValue, 8'h00);
      chk("init bit in reset", {7'h00, initRecoverySequencerBit}, 8'h00);
      rst = 1'b0;
      rd(8'h4D, val); chk("entry13 after reset", val, 8'hA5);
      rd(8'h4E, val); chk("entry14 after reset", val, 8'hE6);
      rd(8'h4F, val); chk("entry15 after reset", val, 8'hF9);
      rd(8'h55, val); chk("control after reset", val, 8'h00);
      // write and read in one cycle: the read returns the old byte
      regReq = '{addr: 8'h4D, wr: 1'b1, rd: 1'b1, wdata: 8'h3C};
      step();
      regReq = '0;
      chk("write read old", regRdData, 8'hA5);
      step();
      rd(8'h4D, val); chk("write read new", val, 8'h3C);
      end_of_test();
   end
endmodule
